// >>> src/kmc_pkg.sv
package kmc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int LONG_PRESS_MS = 2000;
    localparam int LONG_PRESS_CYC = (LONG_PRESS_MS * (CLK_HZ / 1000));
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = (BLINK_MS * (CLK_HZ / 1000));
    // ------------------------------------------------------------
    // Key indices
    // ------------------------------------------------------------
    localparam int NKEYS = 7;
    localparam int K_TEACH = 0;
    localparam int K_INT = 1;
    localparam int K_SETTINGS = 2;
    localparam int K_ABORT = 3;
    localparam int K_ERASE = 4;
    localparam int K_LEFT = 5;
    localparam int K_RIGHT = 6;
    localparam int K_ENTER = K_INT;
    localparam int K_SPREAD = K_ABORT;
    // ------------------------------------------------------------
    // Modulation
    // ------------------------------------------------------------
    localparam logic [6:0] MOD_STEP = 7'h0A;
    localparam logic [6:0] MOD_MAX = 7'h64;
    localparam logic [6:0] MOD_AUTO_TARGET = 7'h50;
    localparam logic [6:0] MOD_RESET = 7'h50;
    typedef enum logic [2:0] {
        KMC_OPER,
        KMC_TEACH,
        KMC_SPREAD,
        KMC_INTENS,
        KMC_SETTINGS,
        KMC_ERASE
    } kmc_mode_t;
endpackage : kmc_pkg

// >>> src/kmc_key_if.sv
`timescale 1ns/1ns
`default_nettype none
interface kmc_key_if;
    logic short_evt;
    logic long_evt;
    logic long_held;
    modport drv (output short_evt, output long_evt, output long_held);
    modport use_p (input short_evt, input long_evt, input long_held);
endinterface : kmc_key_if
`default_nettype wire

// >>> src/kmc_key_timer.sv
`timescale 1ns/1ns
`default_nettype none
module kmc_key_timer #(
    parameter int LONG_CYC = kmc_pkg::LONG_PRESS_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic key,
    kmc_key_if.drv ev
);
    import kmc_pkg::*;
    localparam int CW = $clog2(LONG_CYC + 1);
    initial begin
        if (LONG_CYC < 2) $error("LONG_CYC too small");
    end
    logic [CW-1:0] cnt;
    logic key_d;
    logic reached;
    wire at_thresh = (cnt == CW'(LONG_CYC - 1));
    wire release_evt = key_d && !key;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            key_d <= 1'b0;
            reached <= 1'b0;
            ev.short_evt <= 1'b0;
            ev.long_evt <= 1'b0;
        end else begin
            key_d <= key;
            ev.long_evt <= key && !reached && at_thresh;
            ev.short_evt <= release_evt && !reached;
            if (!key) begin
                cnt <= '0;
                reached <= 1'b0;
            end else if (!reached) begin
                cnt <= cnt + CW'(1);
                if (at_thresh) reached <= 1'b1;
            end
        end
    end
    assign ev.long_held = reached;
endmodule : kmc_key_timer
`default_nettype wire

// >>> src/kmc_top.sv

`timescale 1ns/1ns
`default_nettype none
module kmc_top #(
    parameter int NOUT = 8,
    parameter int LONG_CYC = kmc_pkg::LONG_PRESS_CYC,
    parameter int BLINK_CYCLES = kmc_pkg::BLINK_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [kmc_pkg::NKEYS-1:0] keys,
    input wire logic colour_valid,
    input wire logic [NOUT-1:0] colour_outputs,
    input wire logic [6:0] rx_level,
    input wire logic rx_overmod,
    input wire logic auto_done,
    output logic [NOUT-1:0] switch_out,
    output logic [NOUT-1:0] out_led,
    output logic [kmc_pkg::NKEYS-1:0] key_led,
    output logic locked,
    output logic [2:0] menu_mode,
    output logic item_prev,
    output logic item_next,
    output logic action_evt,
    output logic commit_evt,
    output logic discard_evt,
    output logic auto_start,
    output logic auto_busy,
    output logic [6:0] mod_level
);
    import kmc_pkg::*;
    initial begin
        if (NOUT != 3 && NOUT != 8) $error("NOUT must be 3 or 8");
        if (LONG_CYC < 2) $error("LONG_CYC too small");
        if (BLINK_CYCLES < 1) $error("BLINK_CYCLES must be positive");
    end

    // ------------------------------------------------------------
    // Key timing
    // ------------------------------------------------------------
    kmc_key_if kev [NKEYS] ();
    logic [NKEYS-1:0] sh;
    logic [NKEYS-1:0] lg;
    logic [NKEYS-1:0] held;
    for (genvar g = 0; g < NKEYS; g++) begin : g_key
        kmc_key_timer #(.LONG_CYC(LONG_CYC)) u_tmr (
            .mclk(mclk),
            .rst_n(rst_n),
            .key(keys[g]),
            .ev(kev[g])
        );
        assign sh[g] = kev[g].short_evt;
        assign lg[g] = kev[g].long_evt;
        assign held[g] = kev[g].long_held;
    end

    // ------------------------------------------------------------
    // Key lock sequence
    // ------------------------------------------------------------
    // Sequence runs on short presses; any other short press restarts it
    logic [1:0] seq;
    logic [1:0] next_seq;
    logic next_locked;
    wire any_sh = |sh;
    wire sh_abort = sh[K_ABORT];
    wire sh_enter = sh[K_ENTER];
    wire only_abort = sh_abort && (sh == (NKEYS'(1) << K_ABORT));
    wire only_enter = sh_enter && (sh == (NKEYS'(1) << K_ENTER));
    wire seq_done = (seq == 2'h2) && only_abort;
    always_comb begin
        next_seq = seq;
        next_locked = locked;
        if (any_sh) begin
            unique case (seq)
                2'h0: next_seq = only_abort ? 2'h1 : 2'h0;
                2'h1: next_seq = only_enter ? 2'h2 : (only_abort ? 2'h1 : 2'h0);
                2'h2: next_seq = only_abort ? 2'h0 : 2'h0;
                default: next_seq = 2'h0;
            endcase
        end
        if (seq_done) next_locked = !locked;
    end
    // Lock gates every key action except the sequence itself and the key_led of long-held keys
    wire [NKEYS-1:0] s_ok = locked ? '0 : sh;
    wire [NKEYS-1:0] l_ok = locked ? '0 : lg;

    // ------------------------------------------------------------
    // Menu state
    // ------------------------------------------------------------
    kmc_mode_t mode;
    kmc_mode_t next_mode;
    wire in_menu = (mode != KMC_OPER);
    wire do_commit = in_menu && l_ok[K_ENTER];
    wire do_discard = in_menu && l_ok[K_ABORT];
    always_comb begin
        next_mode = mode;
        unique case (mode)
            KMC_OPER: begin
                if (l_ok[K_TEACH]) next_mode = KMC_TEACH;
                else if (l_ok[K_INT]) next_mode = KMC_INTENS;
                else if (l_ok[K_SETTINGS]) next_mode = KMC_SETTINGS;
                else if (l_ok[K_ERASE]) next_mode = KMC_ERASE;
            end
            KMC_TEACH: begin
                if (s_ok[K_SPREAD]) next_mode = KMC_SPREAD;
            end
            KMC_SPREAD: begin
                if (s_ok[K_TEACH]) next_mode = KMC_TEACH;
            end
            KMC_INTENS, KMC_SETTINGS, KMC_ERASE: begin
            end
        endcase
        if (do_commit || do_discard) next_mode = KMC_OPER;
    end

    // ------------------------------------------------------------
    // Intensity and automatic modulation
    // ------------------------------------------------------------
    wire in_int = (mode == KMC_INTENS);
    wire start_auto = in_int && s_ok[K_TEACH] && !auto_busy;
    wire up_ok = in_int && s_ok[K_RIGHT] && !auto_busy;
    wire dn_ok = in_int && s_ok[K_LEFT] && !auto_busy;
    wire [7:0] mod_up = {1'b0, mod_level} + {1'b0, MOD_STEP};
    logic [6:0] mod_saved;
    logic [6:0] next_mod;
    always_comb begin
        next_mod = mod_level;
        if (do_discard) next_mod = mod_saved;
        else if (up_ok) next_mod = (mod_up[7:0] > {1'b0, MOD_MAX}) ? MOD_MAX : mod_up[6:0];
        else if (dn_ok) next_mod = (mod_level < MOD_STEP) ? 7'h00 : mod_level - MOD_STEP;
        else if (auto_busy && auto_done) next_mod = MOD_AUTO_TARGET;
    end
    logic auto_ok;

    // ------------------------------------------------------------
    // Blink timebase
    // ------------------------------------------------------------
    localparam int BW = $clog2(BLINK_CYCLES + 1);
    logic [BW-1:0] bcnt;
    logic phase;
    wire bwrap = (bcnt == BW'(BLINK_CYCLES - 1));

    // ------------------------------------------------------------
    // LED display
    // ------------------------------------------------------------
    // Bar length scales the 0..100 level onto NOUT LEDs
    logic [NOUT-1:0] bar;
    logic [NOUT-1:0] even_mask;
    logic [NOUT-1:0] next_led;
    logic [NOUT-1:0] next_sw;
    logic [NKEYS-1:0] next_kled;
    wire [6:0] bar_src = auto_ok ? mod_level : rx_level;
    always_comb begin
        for (int i = 0; i < NOUT; i++) begin
            bar[i] = (32'(bar_src) * NOUT) > (32'(i) * 32'(MOD_MAX));
            even_mask[i] = (i % 2) == 0;
        end
    end
    always_comb begin
        next_sw = colour_valid ? colour_outputs : '1;
        next_led = next_sw;
        if (in_int) begin
            if (auto_busy) next_led = phase ? even_mask : ~even_mask;
            else if (rx_overmod) next_led = phase ? '1 : '0;
            else next_led = bar;
        end
        next_kled = held;
        if (in_int && auto_ok) next_kled[K_INT] = 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq <= 2'h0;
        end else begin
            seq <= next_seq;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            locked <= 1'b0;
        end else begin
            locked <= next_locked;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= KMC_OPER;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mod_level <= MOD_RESET;
        end else begin
            mod_level <= next_mod;
        end
    end

    // Snapshot taken outside menus so a discard can restore the level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mod_saved <= MOD_RESET;
        end else if (!in_menu) begin
            mod_saved <= mod_level;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt <= '0;
        end else begin
            bcnt <= bwrap ? '0 : bcnt + BW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
        end else if (bwrap) begin
            phase <= !phase;
        end
    end

    // Leaving the menu drops a run so the LEDs never freeze in the blink pattern
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            auto_busy <= 1'b0;
        end else if (start_auto) begin
            auto_busy <= 1'b1;
        end else if (auto_done || !in_int) begin
            auto_busy <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            auto_ok <= 1'b0;
        end else if (auto_busy && auto_done) begin
            auto_ok <= 1'b1;
        end else if (!in_int || start_auto || up_ok || dn_ok) begin
            auto_ok <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            switch_out <= '1;
        end else begin
            switch_out <= next_sw;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_led <= '1;
        end else begin
            out_led <= next_led;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_led <= '0;
        end else begin
            key_led <= next_kled;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            menu_mode <= 3'h0;
        end else begin
            menu_mode <= 3'(next_mode);
        end
    end

    // Arrows in the intensity menu steer modulation, not the item selection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            item_prev <= 1'b0;
        end else begin
            item_prev <= in_menu && !in_int && s_ok[K_LEFT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            item_next <= 1'b0;
        end else begin
            item_next <= in_menu && !in_int && s_ok[K_RIGHT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            action_evt <= 1'b0;
        end else begin
            action_evt <= in_menu && !in_int && s_ok[K_TEACH];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            commit_evt <= 1'b0;
        end else begin
            commit_evt <= do_commit;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            discard_evt <= 1'b0;
        end else begin
            discard_evt <= do_discard;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            auto_start <= 1'b0;
        end else begin
            auto_start <= start_auto;
        end
    end
endmodule : kmc_top
`default_nettype wire

// >>> verification/kmc_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module kmc_top_chk #(
    parameter int NOUT = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic colour_valid,
    input wire logic rx_overmod,
    input wire logic [NOUT-1:0] switch_out,
    input wire logic [NOUT-1:0] out_led,
    input wire logic [kmc_pkg::NKEYS-1:0] key_led,
    input wire logic locked,
    input wire logic [2:0] menu_mode,
    input wire logic item_prev,
    input wire logic item_next,
    input wire logic action_evt,
    input wire logic commit_evt,
    input wire logic discard_evt,
    input wire logic auto_start,
    input wire logic auto_busy,
    input wire logic [6:0] mod_level
);
    // ----
    // Helpers
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Neighbouring LEDs always differ while the two groups alternate
    wire logic alt_ok = ((out_led ^ (out_led >> 1)) | (1 << (NOUT - 1))) == {NOUT{1'b1}};
    sequence s_overmod;
        (menu_mode == 3'h3 && rx_overmod && !auto_busy) [*3];
    endsequence
    sequence s_busy;
        auto_busy [*3];
    endsequence
    // ----
    // Properties
    // ----
    AST_NO_COLOUR: assert property (!colour_valid [*3] |-> &switch_out)
        else $error("outputs not all high without colour");
    AST_COMMIT: assert property (commit_evt |-> menu_mode == 3'h0 && $past(menu_mode) != 3'h0
        ##1 !commit_evt) else $error("commit without return");
    AST_DISCARD: assert property (discard_evt |-> menu_mode == 3'h0 && $past(menu_mode) != 3'h0
        ##1 !discard_evt) else $error("discard without return");
    AST_ACTION: assert property (action_evt |-> $past(menu_mode) != 3'h0 &&
        $past(menu_mode) != 3'h3 ##1 !action_evt) else $error("action pulse misplaced");
    AST_ITEM: assert property ((item_prev || item_next) |-> $past(menu_mode) != 3'h0 &&
        $past(menu_mode) != 3'h3 && !(item_prev && item_next))
        else $error("item step misplaced");
    AST_AUTO_START: assert property (auto_start |-> menu_mode == 3'h3 ##[0:1] auto_busy)
        else $error("auto start without busy");
    AST_ANTIPHASE: assert property (s_busy |-> alt_ok)
        else $error("auto blink not antiphase");
    AST_OVERMOD: assert property (s_overmod |-> (out_led == '0 || &out_led))
        else $error("overmodulation blink not uniform");
    AST_AUTO_DONE: assert property ($fell(auto_busy) && menu_mode == 3'h3 |->
        mod_level == 7'h50 ##1 key_led[1]) else $error("auto end state wrong");
    AST_STEP: assert property ($changed(mod_level) && !auto_busy && !$past(auto_busy) &&
        !discard_evt && !$past(discard_evt) |-> menu_mode == 3'h3 &&
        (mod_level == $past(mod_level) + 7'h0A || mod_level + 7'h0A == $past(mod_level)))
        else $error("modulation step wrong");
    AST_LOCKED: assert property (locked && $past(locked) |-> $stable(menu_mode))
        else $error("menu changed while locked");
endmodule : kmc_top_chk
bind kmc_top kmc_top_chk #(.NOUT(NOUT)) u_kmc_top_chk (.*);
`default_nettype wire

// >>> verification/kmc_operator.sv
`timescale 1ns/1ns
`default_nettype none
module kmc_operator (
    input wire logic mclk,
    output var logic [6:0] keys
);
    // Bounce is not modelled: the design takes the keys as synchronous levels
    initial keys = '0;
    task automatic down(input int k);
        @(negedge mclk);
        keys[k] = 1'b1;
    endtask : down
    task automatic up(input int k);
        @(negedge mclk);
        keys[k] = 1'b0;
    endtask : up
endmodule : kmc_operator
`default_nettype wire

// >>> verification/keypad_menu_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
module keypad_menu_control_test;
    import kmc_pkg::*;
    localparam int NOUT = 8;
    localparam int LC = 20;
    logic mclk = 0, rst_n = 0, colour_valid = 0, rx_overmod = 0, auto_done = 0;
    logic [NOUT-1:0] colour_outputs = '0, switch_out, out_led;
    logic [6:0] rx_level = '0, mod_level;
    logic [NKEYS-1:0] key_led;
    wire [NKEYS-1:0] keys;
    logic locked, item_prev, item_next, action_evt, commit_evt, discard_evt;
    logic auto_start, auto_busy;
    logic [2:0] menu_mode;
    int error_cnt = 0, n_compared = 0, cyc = 0, mode = 0, lvl = 80, lk = 0, on, off;
    int cnt[6] = '{default: 0};
    int ex[6] = '{default: 0};
    wire logic [5:0] pv = {auto_start, discard_evt, commit_evt, action_evt, item_next, item_prev};
    kmc_top #(.NOUT(NOUT), .LONG_CYC(LC), .BLINK_CYCLES(4)) u_kmc_top (.*);
    kmc_operator u_kmc_operator (.*);
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        for (int i = 0; i < 6; i++) cnt[i] += pv[i];
        cyc++;
        // Whole run needs under a thousand cycles
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ----
    // Model and helpers
    // ----
    function automatic logic [NOUT-1:0] bar(input int lv);
        for (int i = 0; i < NOUT; i++) bar[i] = lv * NOUT > i * 100;
    endfunction : bar
    task automatic chk_all();
        for (int i = 0; i < 6; i++) `CMP(cnt[i], ex[i])
        `CMP(menu_mode, 3'(mode))
        `CMP(mod_level, 7'(lvl))
        `CMP(locked, 1'(lk))
    endtask : chk_all
    task automatic press(input int k, input int n);
        u_kmc_operator.down(k);
        repeat (n) @(negedge mclk);
        if (n > LC + 3) `CMP(key_led[k], 1'b1)
        u_kmc_operator.up(k);
        repeat (8) @(negedge mclk);
    endtask : press
    task automatic lock_seq();
        press(K_ABORT, 5);
        press(K_ENTER, 5);
        press(K_ABORT, 5);
        lk = 1 - lk;
        chk_all();
    endtask : lock_seq
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // ----
    // Scenarios
    // ----
    initial begin
        void'($urandom(32'h5796));
        colour_outputs = NOUT'($urandom);
        repeat (12) @(negedge mclk);
        rst_n = 1;
        `CMP({switch_out, out_led}, {2 * NOUT{1'b1}})
        colour_valid = 1;
        repeat (2) @(negedge mclk);
        `CMP({switch_out, out_led}, {2{colour_outputs}})
        colour_valid = 0;
        repeat (2) @(negedge mclk);
        `CMP({switch_out, out_led}, {2 * NOUT{1'b1}})
        press(K_TEACH, 30);
        mode = 1;
        chk_all();
        press(K_RIGHT, LC - 3);
        press(K_LEFT, 5);
        press(K_TEACH, 5);
        ex[1]++;
        ex[0]++;
        ex[2]++;
        chk_all();
        press(K_SPREAD, 5);
        mode = 2;
        chk_all();
        press(K_TEACH, 5);
        ex[2]++;
        mode = 1;
        chk_all();
        press(K_ENTER, 30);
        ex[3]++;
        mode = 0;
        chk_all();
        press(K_INT, 30);
        mode = 3;
        for (int i = 0; i < 4; i++) begin
            rx_level = 7'($urandom_range(100));
            repeat (4) @(negedge mclk);
            `CMP(out_led, bar(rx_level))
        end
        for (int i = 0; i < 14; i++) begin
            press(i < 3 ? K_RIGHT : K_LEFT, 5);
            lvl = i < 3 ? (lvl < 100 ? lvl + 10 : 100) : (lvl > 0 ? lvl - 10 : 0);
            chk_all();
        end
        rx_overmod = 1;
        repeat (3) @(negedge mclk);
        on = 0;
        off = 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge mclk);
            on += &out_led;
            off += out_led == '0;
        end
        `CMP(on > 0 && off > 0 && on + off == 20, 1'b1)
        rx_overmod = 0;
        rx_level = 7'h14;
        press(K_TEACH, 5);
        ex[5]++;
        `CMP(auto_busy, 1'b1)
        press(K_RIGHT, 5);
        `CMP(out_led == 8'h55 || out_led == 8'hAA, 1'b1)
        auto_done = 1;
        @(negedge mclk);
        auto_done = 0;
        repeat (4) @(negedge mclk);
        lvl = 80;
        `CMP({auto_busy, key_led[K_INT], out_led}, {2'b01, bar(80)})
        chk_all();
        press(K_RIGHT, 5);
        lvl = 90;
        chk_all();
        press(K_ABORT, 30);
        ex[4]++;
        mode = 0;
        lvl = 80;
        chk_all();
        lock_seq();
        press(K_TEACH, 23);
        chk_all();
        lock_seq();
        tally_and_finish();
    end
endmodule : keypad_menu_control_test
`default_nettype wire
